// ### bench/ldc_loop_front.sv
// Loop sense front end model answering each scan dwell
`timescale 1ns/1ps
module ldc_loop_front #(
    parameter int NUM_CH = 2,
    parameter int LAT = 3
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic scan_start,
    input wire logic [NUM_CH-1:0] excite,
    input wire logic [NUM_CH-1:0][15:0] level,
    input wire logic [NUM_CH-1:0] open_in,
    input wire logic [NUM_CH-1:0] short_in,
    output ldc_pkg::ldc_sense_s sense
);
    import ldc_pkg::*;
    logic [3:0] age_ff;
    always_ff @(posedge clock) begin
        if (!resetn || scan_start) begin
            age_ff <= 4'h0;
        end else if (age_ff != 4'hF) begin
            age_ff <= age_ff + 4'h1;
        end
    end
    always_comb begin
        sense = '0;
        // Idle count toggles so stale data is never trusted
        sense.count = age_ff[0] ? 16'h5A5A : 16'hA5A5;
        for (int i = 0; i < NUM_CH; i++) begin
            if (excite[i] && age_ff == 4'(LAT)) begin
                sense.valid = 1'b1;
                sense.count = level[i];
                sense.open_loop = open_in[i];
                sense.gnd_short = short_in[i];
            end
        end
    end
endmodule : ldc_loop_front

// ### bench/ldc_top_properties.sv
// Port assertions for the loop detector channel logic
`timescale 1ns/1ps
module ldc_top_properties #(
    parameter int NUM_CH = 2,
    parameter int TICK_CYC = 10,
    parameter int SCAN_DWELL = 8
) (
    input wire logic clock,
    input wire logic resetn,
    input wire ldc_pkg::ldc_cfg_s [NUM_CH-1:0] cfg,
    input wire ldc_pkg::ldc_sense_s sense,
    input wire logic [NUM_CH-1:0] fault_reset,
    input wire logic [((NUM_CH > 1) ? $clog2(NUM_CH) : 1)-1:0] scan_sel,
    input wire logic scan_start,
    input wire logic [NUM_CH-1:0] excite,
    input wire logic [NUM_CH-1:0] call_n,
    input wire logic [NUM_CH-1:0] fault_ind,
    input wire logic [NUM_CH-1:0] tuning,
    input wire logic [NUM_CH-1:0] detect
);
    import ldc_pkg::*;
    localparam int SW = (NUM_CH > 1) ? $clog2(NUM_CH) : 1;
    // Forty ticks of tuning plus one tick of phase slack
    localparam int TUNE_LIM = 41 * TICK_CYC;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);
    one_loop_a: assert property ($onehot0(excite))
        else $error("two loops excited at once");
    sel_match_a: assert property (excite != '0 |-> excite[scan_sel])
        else $error("excite differs from scan index");
    dwell_hold_a: assert property (scan_start |=>
        (!scan_start && $stable(scan_sel)) [*6])
        else $error("scan dwell cut short");
    sel_step_a: assert property ($changed(scan_sel) |-> scan_start)
        else $error("scan index moved mid dwell");
    cover property (scan_start);
    cover property ($rose(fault_ind[0]));
    cover property ($fell(call_n[0]));
    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        logic [31:0] tune_cnt_ff;
        logic [31:0] nxt_tune_cnt;
        assign nxt_tune_cnt = tuning[i] ? tune_cnt_ff + 32'h1 : 32'h0;
        always_ff @(posedge clock) begin
            tune_cnt_ff <= resetn ? nxt_tune_cnt : 32'h0;
        end
        tune_bound_a: assert property (tune_cnt_ff <= TUNE_LIM)
            else $error("tuning ran too long");
        off_quiet_a: assert property (
            !cfg[i].enable [*3] |-> call_n[i] && !excite[i])
            else $error("disabled channel active");
        tune_call_a: assert property (tuning[i] [*2] |-> !call_n[i])
            else $error("no call while tuning");
        fault_keep_a: assert property (
            fault_ind[i] && !fault_reset[i] |=> fault_ind[i])
            else $error("fault indication lost");
        fault_set_a: assert property (sense.valid && excite[i] &&
            scan_sel == SW'(i) && (sense.open_loop || sense.gnd_short)
            |=> fault_ind[i])
            else $error("loop fault not latched");
        fault_call_a: assert property (
            $rose(fault_ind[i]) |-> ##[0:2] !call_n[i])
            else $error("no call on loop fault");
    end
endmodule : ldc_top_properties

// ### bench/ldc_top_test.sv
// Self-checking bench for the loop detector channel logic
`timescale 1ns/1ps
module ldc_top_test;
    import ldc_pkg::*;
    localparam int TK = 10;
    localparam int DW = 8;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    ldc_cfg_s [1:0] cfg;
    ldc_sense_s sense;
    logic [1:0] fault_reset = 2'h0;
    logic [0:0] scan_sel;
    logic scan_start;
    logic [1:0] excite, call_n, fault_ind, tuning, detect;
    logic [1:0][15:0] level = {16'h03E8, 16'h03E8};
    logic [1:0] open_in = 2'h0;
    logic [1:0] short_in = 2'h0;
    logic [5:0] obs;
    int fails = 0;
    int n_checks = 0;
    assign obs = {excite[1], call_n[1], fault_ind[0], tuning[0], call_n[0],
        detect[0]};
    always #50 clock = ~clock;
    ldc_top #(.NUM_CH(2), .TICK_CYC(TK), .SCAN_DWELL(DW)) DUT (
        .clock(clock), .resetn(resetn), .cfg(cfg), .sense(sense),
        .fault_reset(fault_reset), .scan_sel(scan_sel),
        .scan_start(scan_start), .excite(excite), .call_n(call_n),
        .fault_ind(fault_ind), .tuning(tuning), .detect(detect));
    ldc_loop_front #(.NUM_CH(2), .LAT(3)) fe (
        .clock(clock), .resetn(resetn), .scan_start(scan_start),
        .excite(excite), .level(level), .open_in(open_in),
        .short_in(short_in), .sense(sense));
    task automatic check(input string nm, input logic exp, input logic got);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %b, seen %b", nm, exp, got);
        end
    endtask : check
    task automatic wait_obs(input int w, input logic v, input int lim,
        input string nm);
        int n;
        n = 0;
        while (obs[w] !== v && n < lim) begin
            @(posedge clock);
            #1;
            n++;
        end
        check(nm, v, obs[w]);
    endtask : wait_obs
    // Samples every cycle so a single glitch is caught
    task automatic hold_obs(input int w, input logic v, input int cyc,
        input string nm);
        logic ok;
        ok = 1'b1;
        repeat (cyc) begin
            @(posedge clock);
            #1;
            if (obs[w] !== v) ok = 1'b0;
        end
        check(nm, v, ok ? v : ~v);
    endtask : hold_obs
    task automatic lv(input logic [15:0] v);
        @(posedge clock);
        level[0] <= v;
    endtask : lv
    task automatic complete_run;
        $display("checks %0d, mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run
    initial begin
        repeat (30000) @(posedge clock);
        fails++;
        complete_run();
    end
    initial begin
        cfg[0] = '{1'b1, 3'h0, 1'b0, 5'h00, 6'h00};
        cfg[1] = '{1'b1, 3'h0, 1'b0, 5'h00, 6'h00};
        repeat (3) @(posedge clock);
        resetn <= 1'b1;
        wait_obs(2, 1'b1, 5, "tuning");
        wait_obs(1, 1'b0, 3, "call while tuning");
        wait_obs(2, 1'b0, 41 * TK + 20, "tune time");
        wait_obs(1, 1'b1, 40, "idle call");
        $display("test tune done");
        lv(16'h0384);
        hold_obs(0, 1'b0, 4 * DW, "detect at sens 0");
        @(posedge clock);
        cfg[0].sens <= 3'h1;
        wait_obs(0, 1'b1, 4 * DW, "detect at sens 1");
        lv(16'h03E8);
        wait_obs(0, 1'b0, 4 * DW, "detect clear");
        $display("test sensitivity done");
        @(posedge clock);
        cfg[0].dly_sec <= 5'h01;
        cfg[0].ext_qt <= 6'h04;
        lv(16'h0352);
        wait_obs(0, 1'b1, 4 * DW, "vehicle seen");
        hold_obs(1, 1'b1, 2 * TK, "call held by delay");
        wait_obs(1, 1'b0, 3 * TK + 5, "call after delay");
        lv(16'h03E8);
        wait_obs(0, 1'b0, 4 * DW, "vehicle gone");
        hold_obs(1, 1'b0, 2 * TK, "call extended");
        wait_obs(1, 1'b1, 3 * TK, "extension over");
        lv(16'h0352);
        wait_obs(1, 1'b0, 8 * TK, "call again");
        lv(16'h03E8);
        wait_obs(0, 1'b0, 4 * DW, "vehicle gone");
        lv(16'h0352);
        wait_obs(0, 1'b1, 4 * DW, "vehicle back");
        hold_obs(1, 1'b0, 5 * TK, "call renewed");
        lv(16'h03E8);
        cfg[0].dly_sec <= 5'h00;
        cfg[0].ext_qt <= 6'h00;
        wait_obs(1, 1'b1, 8 * TK, "call ends");
        $display("test timing done");
        for (int k = 0; k < 3; k++) begin
            @(posedge clock);
            if (k == 0) open_in[0] <= 1'b1;
            else if (k == 1) short_in[0] <= 1'b1;
            else level[0] <= 16'h02BC;
            wait_obs(3, 1'b1, 4 * DW, "fault latched");
            wait_obs(1, 1'b0, 3, "call on fault");
            @(posedge clock);
            open_in[0] <= 1'b0;
            short_in[0] <= 1'b0;
            level[0] <= 16'h03E8;
            wait_obs(2, 1'b1, 4 * DW, "retune");
            wait_obs(2, 1'b0, 41 * TK, "retune done");
            check("fault kept", 1'b1, obs[3]);
            @(posedge clock);
            fault_reset[0] <= 1'b1;
            @(posedge clock);
            fault_reset[0] <= 1'b0;
            wait_obs(3, 1'b0, 3, "fault cleared");
        end
        $display("test faults done");
        // Disable only just after channel 0 starts a dwell, so the skip
        // never cuts a running dwell short
        do begin
            @(posedge clock);
            #1;
        end while (!(scan_start === 1'b1 && scan_sel === 1'b0));
        @(posedge clock);
        cfg[1].enable <= 1'b0;
        repeat (3) @(posedge clock);
        hold_obs(4, 1'b1, 4 * DW, "disabled call");
        hold_obs(5, 1'b0, 4 * DW, "disabled scan");
        lv(16'h0352);
        wait_obs(0, 1'b1, 4 * DW, "other channel runs");
        wait_obs(1, 1'b0, 3, "presence call");
        hold_obs(1, 1'b0, 950 * TK, "presence hold");
        wait_obs(2, 1'b1, 30 * TK, "presence limit");
        $display("test disable and presence done");
        complete_run();
    end
endmodule : ldc_top_test
bind ldc_top ldc_top_properties #(
    .NUM_CH(NUM_CH), .TICK_CYC(TICK_CYC), .SCAN_DWELL(SCAN_DWELL)
) chk (
    .clock(clock), .resetn(resetn), .cfg(cfg), .sense(sense),
    .fault_reset(fault_reset), .scan_sel(scan_sel),
    .scan_start(scan_start), .excite(excite), .call_n(call_n),
    .fault_ind(fault_ind), .tuning(tuning), .detect(detect));

// ### common/ldc_defines.svh
// Constants for the loop detector channel logic
// Summary of operation
// - Scan channels one at a time, fixed order
// - Per-channel disable stops that channel only
// - Eight sensitivity levels set detection threshold
// - Lower class presence holds call four minutes
// - Higher class presence holds call sixty minutes
// - Delay 0 to 30 s, one second steps
// - Extension 0 to 15 s, quarter second steps
// - Both allowed; delay always runs first
// - Actuation during extension renews call without delay
// - Call forced while tuning, faulted or unpowered
// - Tuning finishes within ten seconds after power
// - Retune within ten seconds after fault clears
// - Fault indication latched until manual reset
// - Open loop and ground short are faults
// - Quarter inductance drop from tuned value faults
// - Shared loop safe: only one channel excited
`ifndef LDC_DEFINES_SVH
`define LDC_DEFINES_SVH

`define LDC_CLK_HZ 10000000
`define LDC_QTICK_MS 250
`define LDC_QTICK_CYC (`LDC_CLK_HZ / 1000 * `LDC_QTICK_MS)
`define LDC_QT_PER_SEC (1000 / `LDC_QTICK_MS)

`define LDC_DLY_MAX_SEC 30
`define LDC_EXT_MAX_SEC 15
`define LDC_EXT_MAX_QT (`LDC_EXT_MAX_SEC * `LDC_QT_PER_SEC)

`define LDC_TUNE_SEC 10
`define LDC_TUNE_QT (`LDC_TUNE_SEC * `LDC_QT_PER_SEC)

`define LDC_PRES2_MIN 4
`define LDC_PRES3_MIN 60
`define LDC_PRES2_QT (`LDC_PRES2_MIN * 60 * `LDC_QT_PER_SEC)
`define LDC_PRES3_QT (`LDC_PRES3_MIN * 60 * `LDC_QT_PER_SEC)

`define LDC_SENS_BASE 3
`define LDC_FAULT_SHIFT 2
`define LDC_SCAN_DWELL 64
`define LDC_NUM_CH 2
`define LDC_CNT_W 16
`define LDC_TMR_W 8
`define LDC_HOLD_W 16

`endif

// ### common/ldc_pkg.sv
// Types shared by the loop detector channel logic
`include "ldc_defines.svh"
package ldc_pkg;

    typedef enum logic [1:0] {
        LDC_CH_OFF,
        LDC_CH_TUNE,
        LDC_CH_RUN,
        LDC_CH_FAULT
    } ldc_mode_e;

    typedef enum logic [1:0] {
        LDC_T_IDLE,
        LDC_T_DELAY,
        LDC_T_CALL,
        LDC_T_EXT
    } ldc_tstate_e;

    typedef struct packed {
        logic enable;
        logic [2:0] sens;
        logic class3;
        logic [4:0] dly_sec;
        logic [5:0] ext_qt;
    } ldc_cfg_s;

    typedef struct packed {
        logic valid;
        logic [`LDC_CNT_W-1:0] count;
        logic open_loop;
        logic gnd_short;
    } ldc_sense_s;

    typedef struct packed {
        ldc_mode_e mode;
        logic [`LDC_CNT_W-1:0] ref_cnt;
        logic [`LDC_HOLD_W-1:0] hold_cnt;
        logic det;
        logic fault_flag;
    } ldc_ch_s;

    typedef struct packed {
        ldc_tstate_e st;
        logic [`LDC_TMR_W-1:0] cnt;
        logic call;
    } ldc_tmr_s;

endpackage : ldc_pkg

// ### core/ldc_chan_timer.sv
// Delay and extension timer for one detector channel
`timescale 1ns/1ps
`include "ldc_defines.svh"
module ldc_chan_timer (
    input wire logic clock,
    input wire logic resetn,
    input wire logic qtick,
    input wire logic run,
    input wire logic det,
    input wire logic [4:0] dly_sec,
    input wire logic [5:0] ext_qt,
    output logic call
);
    import ldc_pkg::*;

    ldc_tmr_s s_ff;
    ldc_tmr_s nxt_s;
    logic [`LDC_TMR_W-1:0] dly_q;
    logic [`LDC_TMR_W-1:0] ext_q;

    // Out-of-range settings are clamped to the top of the range
    always_comb begin
        if (dly_sec > 5'(`LDC_DLY_MAX_SEC)) begin
            dly_q = `LDC_TMR_W'(`LDC_DLY_MAX_SEC * `LDC_QT_PER_SEC);
        end else begin
            dly_q = `LDC_TMR_W'(dly_sec) * `LDC_TMR_W'(`LDC_QT_PER_SEC);
        end
        if (ext_qt > 6'(`LDC_EXT_MAX_QT)) begin
            ext_q = `LDC_TMR_W'(`LDC_EXT_MAX_QT);
        end else begin
            ext_q = `LDC_TMR_W'(ext_qt);
        end
    end

    // First tick may fall early, so a delay runs up to one tick short
    always_comb begin
        nxt_s = s_ff;
        if (!run) begin
            nxt_s.st = LDC_T_IDLE;
            nxt_s.cnt = '0;
        end else begin
            unique case (s_ff.st)
                LDC_T_IDLE: begin
                    if (det && dly_q == '0) begin
                        nxt_s.st = LDC_T_CALL;
                    end else if (det) begin
                        nxt_s.st = LDC_T_DELAY;
                        nxt_s.cnt = dly_q;
                    end
                end
                LDC_T_DELAY: begin
                    if (!det) begin
                        nxt_s.st = LDC_T_IDLE;
                    end else if (qtick && s_ff.cnt <= `LDC_TMR_W'(1)) begin
                        nxt_s.st = LDC_T_CALL;
                    end else if (qtick) begin
                        nxt_s.cnt = s_ff.cnt - `LDC_TMR_W'(1);
                    end
                end
                LDC_T_CALL: begin
                    if (!det && ext_q == '0) begin
                        nxt_s.st = LDC_T_IDLE;
                    end else if (!det) begin
                        nxt_s.st = LDC_T_EXT;
                        nxt_s.cnt = ext_q;
                    end
                end
                LDC_T_EXT: begin
                    if (det) begin
                        nxt_s.st = LDC_T_CALL;
                    end else if (qtick && s_ff.cnt <= `LDC_TMR_W'(1)) begin
                        nxt_s.st = LDC_T_IDLE;
                    end else if (qtick) begin
                        nxt_s.cnt = s_ff.cnt - `LDC_TMR_W'(1);
                    end
                end
            endcase
        end
        nxt_s.call = (nxt_s.st == LDC_T_CALL) || (nxt_s.st == LDC_T_EXT);
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign call = s_ff.call;

endmodule : ldc_chan_timer

// ### core/ldc_top.sv
// Multi-channel loop detector scan, tuning, fault and call logic
`timescale 1ns/1ps
`include "ldc_defines.svh"
module ldc_top #(
    parameter int NUM_CH = `LDC_NUM_CH,
    parameter int TICK_CYC = `LDC_QTICK_CYC,
    parameter int SCAN_DWELL = `LDC_SCAN_DWELL
) (
    input wire logic clock,
    input wire logic resetn,
    input wire ldc_pkg::ldc_cfg_s [NUM_CH-1:0] cfg,
    input wire ldc_pkg::ldc_sense_s sense,
    input wire logic [NUM_CH-1:0] fault_reset,
    output logic [((NUM_CH > 1) ? $clog2(NUM_CH) : 1)-1:0] scan_sel,
    output logic scan_start,
    output logic [NUM_CH-1:0] excite,
    output logic [NUM_CH-1:0] call_n,
    output logic [NUM_CH-1:0] fault_ind,
    output logic [NUM_CH-1:0] tuning,
    output logic [NUM_CH-1:0] detect
);
    import ldc_pkg::*;

    localparam int CH_W = (NUM_CH > 1) ? $clog2(NUM_CH) : 1;
    localparam int TICK_W = $clog2(TICK_CYC + 1);
    localparam int DW_W = $clog2(SCAN_DWELL + 1);
    localparam int CW = `LDC_CNT_W;
    localparam int HW = `LDC_HOLD_W;

    initial begin
        if (NUM_CH < 1 || NUM_CH > 16) begin
            $error("NUM_CH must be 1 to 16");
        end
        if (TICK_CYC < 1) begin
            $error("TICK_CYC must be at least 1");
        end
        if (SCAN_DWELL < 2) begin
            $error("SCAN_DWELL must be at least 2");
        end
    end

    typedef struct packed {
        logic [TICK_W-1:0] tick_cnt;
        logic qtick;
        logic [CH_W-1:0] idx;
        logic [DW_W-1:0] dwell;
        logic start;
        logic [NUM_CH-1:0] excite;
        ldc_ch_s [NUM_CH-1:0] ch;
        logic [NUM_CH-1:0] call;
    } ldc_state_s;

    ldc_state_s s_ff;
    ldc_state_s nxt_s;
    logic [NUM_CH-1:0] tmr_call;
    logic [NUM_CH-1:0] en_mask;

    // Next enabled channel after idx, wrapping; stays put if none
    function automatic logic [CH_W-1:0] ldc_next_chan(
        input logic [CH_W-1:0] idx,
        input logic [NUM_CH-1:0] en
    );
        logic [CH_W-1:0] res;
        logic found;
        int cand;
        res = idx;
        found = 1'b0;
        for (int k = 1; k <= NUM_CH; k++) begin
            cand = (int'(idx) + k) % NUM_CH;
            if (!found && en[cand]) begin
                res = CH_W'(cand);
                found = 1'b1;
            end
        end
        return res;
    endfunction : ldc_next_chan

    // Inductance drop below tuned value; a rise reads as zero
    function automatic logic [CW-1:0] ldc_drop(
        input logic [CW-1:0] ref_cnt,
        input logic [CW-1:0] count
    );
        logic [CW-1:0] res;
        res = (ref_cnt > count) ? (ref_cnt - count) : '0;
        return res;
    endfunction : ldc_drop

    // Higher level shifts further, giving a smaller threshold
    function automatic logic [CW-1:0] ldc_thresh(
        input logic [CW-1:0] ref_cnt,
        input logic [2:0] sens
    );
        logic [CW-1:0] res;
        res = ref_cnt >> (`LDC_SENS_BASE + int'(sens));
        if (res == '0) begin
            res = CW'(1);
        end
        return res;
    endfunction : ldc_thresh

    generate
        for (genvar g = 0; g < NUM_CH; g++) begin : g_chan
            assign en_mask[g] = cfg[g].enable;
            ldc_chan_timer u_tmr (
                .clock(clock),
                .resetn(resetn),
                .qtick(s_ff.qtick),
                .run(s_ff.ch[g].mode == LDC_CH_RUN),
                .det(s_ff.ch[g].det),
                .dly_sec(cfg[g].dly_sec),
                .ext_qt(cfg[g].ext_qt),
                .call(tmr_call[g])
            );
        end
    endgenerate

    always_comb begin
        logic samp;
        logic hard_flt;
        logic drop_flt;
        logic [CW-1:0] drop;
        logic [CW-1:0] quarter;
        logic [HW-1:0] hold_lim;
        samp = 1'b0;
        hard_flt = 1'b0;
        drop_flt = 1'b0;
        drop = '0;
        quarter = '0;
        hold_lim = '0;
        nxt_s = s_ff;

        // Common quarter-second timebase
        if (s_ff.tick_cnt >= TICK_W'(TICK_CYC - 1)) begin
            nxt_s.tick_cnt = '0;
            nxt_s.qtick = 1'b1;
        end else begin
            nxt_s.tick_cnt = s_ff.tick_cnt + TICK_W'(1);
            nxt_s.qtick = 1'b0;
        end

        // Only one loop oscillator runs at a time, so channels sharing
        // a loop never see each other's excitation
        nxt_s.start = 1'b0;
        if (s_ff.dwell >= DW_W'(SCAN_DWELL - 1)) begin
            nxt_s.dwell = '0;
            nxt_s.idx = ldc_next_chan(s_ff.idx, en_mask);
            nxt_s.start = 1'b1;
        end else begin
            nxt_s.dwell = s_ff.dwell + DW_W'(1);
        end
        if (!en_mask[s_ff.idx]) begin
            nxt_s.idx = ldc_next_chan(s_ff.idx, en_mask);
            nxt_s.dwell = '0;
            nxt_s.start = en_mask != '0;
        end
        nxt_s.excite = '0;
        nxt_s.excite[nxt_s.idx] = en_mask[nxt_s.idx];

        for (int i = 0; i < NUM_CH; i++) begin
            // Results are only taken for the channel now excited
            samp = sense.valid && s_ff.excite[i] &&
                (s_ff.idx == CH_W'(i));
            hard_flt = samp && (sense.open_loop || sense.gnd_short);
            quarter = s_ff.ch[i].ref_cnt >> `LDC_FAULT_SHIFT;
            drop = ldc_drop(s_ff.ch[i].ref_cnt, sense.count);
            drop_flt = samp && (s_ff.ch[i].mode == LDC_CH_RUN) &&
                (drop >= quarter) && (quarter != '0);
            hold_lim = cfg[i].class3 ? HW'(`LDC_PRES3_QT) :
                HW'(`LDC_PRES2_QT);

            unique case (s_ff.ch[i].mode)
                LDC_CH_OFF: begin
                    nxt_s.ch[i].mode = LDC_CH_TUNE;
                    nxt_s.ch[i].hold_cnt = '0;
                end
                LDC_CH_TUNE: begin
                    if (hard_flt) begin
                        nxt_s.ch[i].mode = LDC_CH_FAULT;
                    end else if (samp) begin
                        nxt_s.ch[i].ref_cnt = sense.count;
                        nxt_s.ch[i].mode = LDC_CH_RUN;
                        nxt_s.ch[i].hold_cnt = '0;
                    end else if (s_ff.qtick && s_ff.ch[i].hold_cnt >=
                        HW'(`LDC_TUNE_QT - 1)) begin
                        // No answer from the loop in time: go to fault mode, but fault_flag is not set
                        nxt_s.ch[i].mode = LDC_CH_FAULT;
                        nxt_s.ch[i].hold_cnt = '0;
                    end else if (s_ff.qtick) begin
                        nxt_s.ch[i].hold_cnt =
                            s_ff.ch[i].hold_cnt + HW'(1);
                    end
                    nxt_s.ch[i].det = 1'b0;
                end
                LDC_CH_RUN: begin
                    if (hard_flt || drop_flt) begin
                        nxt_s.ch[i].mode = LDC_CH_FAULT;
                        nxt_s.ch[i].det = 1'b0;
                        nxt_s.ch[i].hold_cnt = '0;
                    end else begin
                        if (samp) begin
                            nxt_s.ch[i].det = drop >= ldc_thresh(
                                s_ff.ch[i].ref_cnt, cfg[i].sens);
                        end
                        if (!s_ff.ch[i].det) begin
                            nxt_s.ch[i].hold_cnt = '0;
                        end else if (s_ff.qtick && s_ff.ch[i].hold_cnt >=
                            hold_lim - HW'(1)) begin
                            // Retune absorbs the parked vehicle
                            nxt_s.ch[i].mode = LDC_CH_TUNE;
                            nxt_s.ch[i].det = 1'b0;
                            nxt_s.ch[i].hold_cnt = '0;
                        end else if (s_ff.qtick) begin
                            nxt_s.ch[i].hold_cnt =
                                s_ff.ch[i].hold_cnt + HW'(1);
                        end
                    end
                end
                LDC_CH_FAULT: begin
                    if (samp && !hard_flt) begin
                        nxt_s.ch[i].mode = LDC_CH_TUNE;
                        nxt_s.ch[i].hold_cnt = '0;
                    end
                    nxt_s.ch[i].det = 1'b0;
                end
            endcase

            if (!cfg[i].enable) begin
                nxt_s.ch[i].mode = LDC_CH_OFF;
                nxt_s.ch[i].det = 1'b0;
                nxt_s.ch[i].hold_cnt = '0;
            end

            // New fault wins over a manual reset in the same cycle
            nxt_s.ch[i].fault_flag = hard_flt || drop_flt ||
                (s_ff.ch[i].fault_flag && !fault_reset[i]);

            nxt_s.call[i] = cfg[i].enable && (tmr_call[i] ||
                (s_ff.ch[i].mode == LDC_CH_TUNE) ||
                (s_ff.ch[i].mode == LDC_CH_FAULT));
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign scan_sel = s_ff.idx;
    assign scan_start = s_ff.start;
    assign excite = s_ff.excite;

    generate
        for (genvar g = 0; g < NUM_CH; g++) begin : g_out
            // Active low, so a dead unit pulls every call on
            assign call_n[g] = !s_ff.call[g];
            assign fault_ind[g] = s_ff.ch[g].fault_flag;
            assign tuning[g] = s_ff.ch[g].mode == LDC_CH_TUNE;
            assign detect[g] = s_ff.ch[g].det;
        end
    endgenerate

endmodule : ldc_top
